// *** core/dsr_readback.sv ***
// Status readback command interpreter of a display driver.
// Assumes a link decoder hands over read opcodes as one-cycle strobes and
// pulls answer bytes with a one-cycle take strobe; the host discards dummies itself.
`timescale 1ns/1ps
module dsr_readback #(
   parameter logic [7:0] ID_MAKER = dsr_pkg::ID_MAKER_DEFAULT,  // Arbitrary value
   parameter logic [7:0] ID_VERSION = dsr_pkg::ID_VERSION_DEFAULT,  // Arbitrary value
   parameter logic [7:0] ID_DEVICE = dsr_pkg::ID_DEVICE_DEFAULT  // Arbitrary value
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic soft_reset,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_opcode,
   input wire logic parity_error,
   input wire dsr_pkg::dsr_state_t disp_state,
   input wire dsr_pkg::dsr_dpi_t dpi_pins,
   input wire logic byte_take,
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic byte_last,
   output logic cmd_unknown
);
   import dsr_pkg::*;

   // ********************
   // Declarations
   // ********************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01
   } dsr_state_e_t;

   dsr_state_e_t st_q;  // Answer sequencer state
   logic [7:0] op_q;  // Opcode being answered
   logic [2:0] idx_q;  // Index of byte now offered
   logic [2:0] last_q;  // Index of final byte
   logic [6:0] pe_cnt_q;  // Parity errors seen
   logic pe_ovf_q;  // Count wrapped past its top
   logic pe_flag_q;  // Sticky status flag
   logic [3:0] dpi_lvl;  // Filtered DPI levels
   logic [31:0] status_word;  // Live status word
   logic [7:0] fmt_byte;  // Pixel format byte
   logic [7:0] ans_d;  // Next answer byte
   logic known;  // Opcode is served here
   logic [2:0] last_d;  // Final index for a new opcode
   logic pe_read_done;  // Count answer taken
   logic any_reset;  // Hardware or software reset

   assign any_reset = srst | soft_reset;

   // ********************
   // DPI pin synchronisers
   // ********************
   // One filtered synchroniser per pin
   genvar gi;
   generate
      for (gi = 0; gi < $bits(dsr_dpi_t); gi++) begin : g_dpi
         logic pin_w;
         assign pin_w = dpi_pins[gi];
         dsr_sync u_sync (
            .mclk(mclk),
            .srst(srst),
            .pin(pin_w),
            .level(dpi_lvl[gi])
         );
      end
   endgenerate

   // ********************
   // Status word and format byte
   // ********************
   // Assemble the live status word; unlisted bits read zero
   always_comb begin
      status_word = '0;
      status_word[PE_FLAG_BIT] = pe_flag_q;
      status_word[DE_BIT] = dpi_lvl[0];
      status_word[PCLK_BIT] = dpi_lvl[1];
      status_word[VSYNC_BIT] = dpi_lvl[2];
      status_word[HSYNC_BIT] = dpi_lvl[3];
      status_word[TE_MODE_BIT] = disp_state.te_mode_both;
      status_word[SCROLL_BIT] = disp_state.scroll_on;
      // Normal only when neither partial nor scrolling
      status_word[NORMAL_BIT] = ~(disp_state.partial_on | disp_state.scroll_on);
      status_word[PARTIAL_BIT] = disp_state.partial_on;
      status_word[ORDER_H_BIT] = disp_state.access_control[MAC_H_BIT];
      status_word[ORDER_BGR_BIT] = disp_state.access_control[MAC_BGR_BIT];
      status_word[ORDER_V_BIT] = disp_state.access_control[MAC_V_BIT];
   end

   // Colour codes pass through; undefined codes are reported unchanged
   always_comb begin
      fmt_byte = {1'b0, disp_state.dsi_format, 1'b0, disp_state.ctrl_format};
   end

   // ********************
   // Answer selection
   // ********************
   // Byte for opcode op_q at index idx_q
   always_comb begin
      ans_d = 8'h00;
      case (op_q)
         OP_READ_IDENTIFICATION: begin
            case (idx_q)
               3'h1: ans_d = ID_MAKER;
               3'h2: ans_d = ID_VERSION;
               3'h3: ans_d = ID_DEVICE;
               default: ans_d = 8'h00;  // Dummy byte
            endcase
         end
         OP_READ_PARITY_ERROR_COUNT: ans_d = {pe_ovf_q, pe_cnt_q};
         OP_READ_RED_COMPONENT: ans_d = {2'b00, disp_state.red[5:1], 1'b0};
         OP_READ_GREEN_COMPONENT: ans_d = {2'b00, disp_state.green};
         OP_READ_BLUE_COMPONENT: ans_d = {2'b00, disp_state.blue[5:1], 1'b0};
         OP_READ_DISPLAY_STATUS_WORD: begin
            case (idx_q)
               3'h1: ans_d = status_word[31:24];
               3'h2: ans_d = status_word[23:16];
               3'h3: ans_d = status_word[15:8];
               3'h4: ans_d = status_word[7:0];
               default: ans_d = 8'h00;  // Dummy byte
            endcase
         end
         OP_READ_PIXEL_FORMAT_BYTE: ans_d = (idx_q == 3'h1) ? fmt_byte : 8'h00;
         default: ans_d = 8'h00;
      endcase
   end

   // Which opcodes are served, and how many bytes each returns
   always_comb begin
      known = 1'b1;
      case (cmd_opcode)
         OP_READ_IDENTIFICATION: last_d = LAST_IDX_ID;
         OP_READ_DISPLAY_STATUS_WORD: last_d = LAST_IDX_STATUS;
         OP_READ_PIXEL_FORMAT_BYTE: last_d = LAST_IDX_DUMMY_ONE;
         OP_READ_PARITY_ERROR_COUNT, OP_READ_RED_COMPONENT, OP_READ_GREEN_COMPONENT,
         OP_READ_BLUE_COMPONENT: last_d = LAST_IDX_ONE;
         default: begin
            last_d = LAST_IDX_ONE;
            known = 1'b0;
         end
      endcase
   end

   // ********************
   // Answer sequencer
   // ********************
   // A new opcode during an answer aborts it, as a command does on the link
   always_ff @(posedge mclk) begin
      if (any_reset) begin
         st_q <= ST_IDLE;
         op_q <= 8'h00;
         idx_q <= 3'h0;
         last_q <= 3'h0;
      end else if (cmd_valid) begin
         st_q <= known ? ST_SEND : ST_IDLE;
         op_q <= cmd_opcode;
         idx_q <= 3'h0;
         last_q <= last_d;
      end else begin
         case (st_q)
            ST_IDLE: st_q <= ST_IDLE;
            ST_SEND: begin
               if (byte_take) begin
                  if (idx_q == last_q) begin
                     st_q <= ST_IDLE;
                  end else begin
                     idx_q <= idx_q + 3'h1;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Answer byte registered so data comes from a flop
   always_ff @(posedge mclk) begin
      if (any_reset) begin
         byte_data <= 8'h00;
      end else begin
         byte_data <= ans_d;
      end
   end

   // Valid trails state by one cycle so it aligns with the registered byte
   logic send_q;
   logic [2:0] data_idx_q;
   always_ff @(posedge mclk) begin
      if (any_reset) begin
         send_q <= 1'b0;
         data_idx_q <= 3'h0;
      end else begin
         send_q <= (st_q == ST_SEND) & ~cmd_valid & ~(byte_take & byte_valid);
         data_idx_q <= idx_q;
      end
   end
   assign byte_valid = send_q;
   assign byte_last = send_q & (data_idx_q == last_q);

   // Unknown opcode pulse for the decoder
   always_ff @(posedge mclk) begin
      if (any_reset) begin
         cmd_unknown <= 1'b0;
      end else begin
         cmd_unknown <= cmd_valid & ~known;
      end
   end

   // ********************
   // Parity error counter
   // ********************
   assign pe_read_done = byte_take & byte_valid & (op_q == OP_READ_PARITY_ERROR_COUNT);

   // A new error in the clearing cycle wins: count restarts at one
   always_ff @(posedge mclk) begin
      if (any_reset) begin
         pe_cnt_q <= 7'h00;
         pe_ovf_q <= 1'b0;
         pe_flag_q <= 1'b0;
      end else if (pe_read_done) begin
         pe_cnt_q <= parity_error ? 7'h01 : 7'h00;
         pe_ovf_q <= 1'b0;
         pe_flag_q <= parity_error;
      end else if (parity_error) begin
         pe_flag_q <= 1'b1;
         if (pe_cnt_q == PE_COUNT_MAX) begin
            pe_ovf_q <= 1'b1;
            pe_cnt_q <= 7'h00;
         end else begin
            pe_cnt_q <= pe_cnt_q + 7'h01;
         end
      end
   end
endmodule

// *** core/dsr_pkg.sv ***
// Package for the display status readback block: opcodes, field positions, reset values.
// Assumes one 10 MHz clock domain and a byte-wide command/answer stream from the link decoder.
package dsr_pkg;
   // ********************
   // Opcodes
   // ********************
   localparam logic [7:0] OP_READ_IDENTIFICATION = 8'h04;
   localparam logic [7:0] OP_READ_PARITY_ERROR_COUNT = 8'h05;
   localparam logic [7:0] OP_READ_RED_COMPONENT = 8'h06;
   localparam logic [7:0] OP_READ_GREEN_COMPONENT = 8'h07;
   localparam logic [7:0] OP_READ_BLUE_COMPONENT = 8'h08;
   localparam logic [7:0] OP_READ_DISPLAY_STATUS_WORD = 8'h09;
   localparam logic [7:0] OP_READ_PIXEL_FORMAT_BYTE = 8'h0c;
   // ********************
   // Identification (values arbitrary, neutral)
   // ********************
   localparam logic [7:0] ID_MAKER_DEFAULT = 8'h5a;
   localparam logic [7:0] ID_VERSION_DEFAULT = 8'h10;
   localparam logic [7:0] ID_DEVICE_DEFAULT = 8'h20;
   // ********************
   // Colour codes and field positions
   // ********************
   localparam logic [2:0] FMT_12BPP = 3'h3;
   localparam logic [2:0] FMT_16BPP = 3'h5;
   localparam logic [2:0] FMT_18BPP = 3'h6;
   localparam logic [2:0] FMT_RESET = 3'h6;
   localparam int PE_FLAG_BIT = 0;
   localparam int DE_BIT = 1;
   localparam int PCLK_BIT = 2;
   localparam int VSYNC_BIT = 3;
   localparam int HSYNC_BIT = 4;
   localparam int TE_MODE_BIT = 5;
   localparam int SCROLL_BIT = 15;
   localparam int NORMAL_BIT = 16;
   localparam int PARTIAL_BIT = 18;
   localparam int ORDER_H_BIT = 25;
   localparam int ORDER_BGR_BIT = 26;
   localparam int ORDER_V_BIT = 27;
   localparam int MAC_H_BIT = 2;
   localparam int MAC_BGR_BIT = 3;
   localparam int MAC_V_BIT = 4;
   localparam logic [6:0] PE_COUNT_MAX = 7'h7f;
   localparam logic [2:0] LAST_IDX_ID = 3'h3;
   localparam logic [2:0] LAST_IDX_STATUS = 3'h4;
   localparam logic [2:0] LAST_IDX_ONE = 3'h0;
   localparam logic [2:0] LAST_IDX_DUMMY_ONE = 3'h1;

   // Display state that the rest of the command set supplies
   typedef struct packed {
      logic [7:0] access_control;  // memory_access_control byte
      logic te_mode_both;          // Tearing output on H and V blanking
      logic partial_on;
      logic scroll_on;
      logic [2:0] dsi_format;
      logic [2:0] ctrl_format;
      logic [5:0] red;
      logic [5:0] green;
      logic [5:0] blue;
   } dsr_state_t;

   // Raw levels of the DPI pins
   typedef struct packed {
      logic hsync;
      logic vsync;
      logic pclk;
      logic data_enable_line;
   } dsr_dpi_t;
endpackage

// *** core/dsr_sync.sv ***
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/1ps
module dsr_sync (
   input wire logic mclk,
   input wire logic srst,
   input wire logic pin,
   output logic level
);
   logic s1_q;  // First stage, read only by s2
   logic s2_q;
   logic s3_q;
   // ********************
   // Stages
   // ********************
   // Shift the pin through three flops
   always_ff @(posedge mclk) begin
      if (srst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // Accept a change only once stages two and three agree
   always_ff @(posedge mclk) begin
      if (srst) begin
         level <= 1'b0;
      end else if (s2_q == s3_q) begin
         level <= s3_q;
      end
   end
endmodule

// *** tb/dsr_readback_sva.sv ***
// Checker for the status readback block.
// Assumes it is bound to dsr_readback and sees only its ports.
`timescale 1ns/1ps
module dsr_readback_sva #(
   parameter logic [7:0] ID_DEVICE = dsr_pkg::ID_DEVICE_DEFAULT  // Arbitrary value
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic soft_reset,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_opcode,
   input wire dsr_pkg::dsr_state_t disp_state,
   input wire logic byte_take,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_last,
   input wire logic cmd_unknown
);
   import dsr_pkg::*;
   // ****
   // Properties
   // ****
   logic [7:0] op_q;  // Command owning the offered bytes
   // Track the command, since the answer bytes do not name it
   always_ff @(posedge mclk) begin
      if (cmd_valid) begin
         op_q <= cmd_opcode;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst || soft_reset);
   sequence s_id_cmd;
      cmd_valid && cmd_opcode == OP_READ_IDENTIFICATION;
   endsequence
   sequence s_red_cmd;
      cmd_valid && cmd_opcode == OP_READ_RED_COMPONENT;
   endsequence
   // Idle gap, then a zero dummy that is not the last byte
   sequence s_dummy;
      !byte_valid ##[1:2] (byte_valid && !byte_last && byte_data == 8'h00);
   endsequence
   sequence s_single;
      !byte_valid ##[1:2] (byte_valid && byte_last);
   endsequence
   a_id_dummy_first: assert property (s_id_cmd |=> s_dummy)
      else $error("identification answer lacks its dummy");
   a_red_single: assert property (s_red_cmd |=> s_single)
      else $error("red answer is not one byte");
   a_red_layout: assert property (byte_valid && op_q == OP_READ_RED_COMPONENT
      |-> byte_data == {2'h0, disp_state.red[5:1], 1'h0}) else $error("red byte wrong");
   a_green_layout: assert property (byte_valid && op_q == OP_READ_GREEN_COMPONENT
      |-> byte_data == {2'h0, disp_state.green}) else $error("green byte wrong");
   a_blue_layout: assert property (byte_valid && op_q == OP_READ_BLUE_COMPONENT
      |-> byte_data == {2'h0, disp_state.blue[5:1], 1'h0}) else $error("blue byte wrong");
   a_format_byte: assert property (byte_valid && byte_last
      && op_q == OP_READ_PIXEL_FORMAT_BYTE
      |-> byte_data == {1'h0, disp_state.dsi_format, 1'h0, disp_state.ctrl_format})
      else $error("format byte wrong");
   a_id_device_last: assert property (byte_valid && byte_last
      && op_q == OP_READ_IDENTIFICATION |-> byte_data == ID_DEVICE) else $error("id wrong");
   a_unknown_pulse: assert property (cmd_valid && !(cmd_opcode inside {8'h04, 8'h05, 8'h06,
      8'h07, 8'h08, 8'h09, 8'h0c}) |=> cmd_unknown ##1 !cmd_unknown) else $error("no refusal");
   a_offer_stands: assert property (byte_valid && !byte_take && !cmd_valid
      |=> byte_valid && $stable(byte_data) && $stable(byte_last)) else $error("offer moved");
   // A new command withdraws whatever answer was on offer
   a_cmd_aborts: assert property (cmd_valid |=> !byte_valid) else $error("offer not withdrawn");
endmodule
bind dsr_readback dsr_readback_sva #(.ID_DEVICE(ID_DEVICE)) u_sva (.mclk(mclk), .srst(srst),
   .soft_reset(soft_reset), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
   .disp_state(disp_state), .byte_take(byte_take), .byte_valid(byte_valid),
   .byte_data(byte_data), .byte_last(byte_last), .cmd_unknown(cmd_unknown));

// *** tb/dsr_host.sv ***
// Host model: takes every offered answer byte, promptly or slowly.
// Assumes byte_take is sampled by the block on the rising edge.
`timescale 1ns/1ps
module dsr_host (
   input wire logic mclk,
   input wire logic [1:0] slow,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic byte_take,
   output logic got_stb,
   output logic [7:0] got_byte
);
   int wait_n = 0;  // Cycles spent stalling on this byte
   initial begin
      byte_take = 1'b0;
      got_stb = 1'b0;
      got_byte = 8'h00;
   end
   // Take after the chosen stall, dummy included; one pulse only
   always @(negedge mclk) begin
      if (byte_valid && !byte_take && wait_n >= slow) begin
         byte_take <= 1'b1;
         wait_n <= 0;
      end else begin
         byte_take <= 1'b0;
         wait_n <= (byte_valid && !byte_take) ? wait_n + 1 : wait_n;
      end
   end
   // Report each byte taken at this edge
   always @(posedge mclk) begin
      got_stb <= byte_valid && byte_take;
      got_byte <= byte_data;
   end
endmodule

// *** tb/testbench.sv ***
// Testbench for the status readback block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module testbench;
   import dsr_pkg::*;
   // ****
   // Stimulus and checks
   // ****
   logic mclk = 0, srst = 1, soft_reset = 0, cmd_valid = 0, parity_error = 0;
   logic [7:0] cmd_opcode = 8'h00;
   dsr_state_t st = '0;
   dsr_dpi_t pins = '0;
   logic [1:0] slow = 2'h0;
   logic byte_take, byte_valid, byte_last, cmd_unknown, got_stb;
   logic [7:0] byte_data, got_byte;
   logic [7:0] q[$];  // Bytes the host took
   logic [2:0] fmts[3] = '{FMT_12BPP, FMT_16BPP, FMT_18BPP};
   logic pe_flag = 0, ov = 0;  // Expected error flag and overflow
   logic [63:0] r;
   int err_total = 0, samples_checked = 0, cyc = 0, pe = 0, i;
   always #50 mclk = ~mclk;
   dsr_readback DUT (.mclk(mclk), .srst(srst), .soft_reset(soft_reset),
      .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .parity_error(parity_error),
      .disp_state(st), .dpi_pins(pins), .byte_take(byte_take), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_last(byte_last), .cmd_unknown(cmd_unknown));
   dsr_host host (.mclk(mclk), .slow(slow), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_take(byte_take), .got_stb(got_stb), .got_byte(got_byte));
   always @(negedge mclk) if (got_stb) q.push_back(got_byte);
   // Hang guard: far above the under two thousand cycles the run needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 20000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (err_total == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Issue one command and wait, bounded, for n bytes
   task automatic run(input logic [7:0] op, input int n);
      int k;
      q.delete();
      cmd_opcode = op;
      cmd_valid = 1;
      @(negedge mclk);
      cmd_valid = 0;
      for (k = 0; k < 80 && q.size() < n; k++) @(negedge mclk);
      repeat (4) @(negedge mclk);
      check(q.size(), n);
   endtask
   // Parity error pulses, with the seven-bit count wrapping
   task automatic errs(input int n);
      repeat (n) begin
         parity_error = 1;
         @(negedge mclk);
         parity_error = 0;
         @(negedge mclk);
         pe_flag = 1;
         ov = ov | (pe == 127);
         pe = (pe + 1) % 128;
      end
   endtask
   // Read the count; reading clears count and flag
   task automatic rd_count();
      run(OP_READ_PARITY_ERROR_COUNT, 1);
      check(q[0], {ov, 7'(pe)});
      pe = 0;
      ov = 0;
      pe_flag = 0;
   endtask
   function automatic logic [31:0] status_word();
      logic [31:0] w;
      w = '0;
      w[0] = pe_flag;
      w[4:1] = pins;
      w[5] = st.te_mode_both;
      w[15] = st.scroll_on;
      w[16] = !(st.partial_on | st.scroll_on);
      w[18] = st.partial_on;
      w[27:25] = st.access_control[4:2];
      return w;
   endfunction
   initial begin
      void'($urandom(32'h42675953));
      repeat (4) @(negedge mclk);
      srst = 0;
      run(OP_READ_IDENTIFICATION, 4);
      check({q[1], q[2], q[3]}, {8'h00, ID_MAKER_DEFAULT, ID_VERSION_DEFAULT, ID_DEVICE_DEFAULT});
      for (i = 0; i < 14; i++) begin
         r = {$urandom, $urandom};
         st = (i < 2) ? {35{i[0]}} : r[34:0];
         st.dsi_format = fmts[i % 3];
         st.ctrl_format = fmts[$urandom % 3];
         pins = 4'($urandom);
         slow = 2'($urandom);
         errs(i % 3);
         repeat (6) @(negedge mclk);
         run(OP_READ_RED_COMPONENT, 1);
         check(q[0], {2'h0, st.red[5:1], 1'h0});
         run(OP_READ_GREEN_COMPONENT, 1);
         check(q[0], {2'h0, st.green});
         run(OP_READ_BLUE_COMPONENT, 1);
         check(q[0], {2'h0, st.blue[5:1], 1'h0});
         run(OP_READ_PIXEL_FORMAT_BYTE, 2);
         check(q[1], {1'h0, st.dsi_format, 1'h0, st.ctrl_format});
         run(OP_READ_DISPLAY_STATUS_WORD, 5);
         check({q[1], q[2], q[3], q[4]} & 32'h0e05_803f, status_word());
         rd_count();
      end
      run(OP_READ_DISPLAY_STATUS_WORD, 5);
      check(q[4][0], 1'b0);
      // Abort a slow status answer with a new command before any byte is taken
      slow = 2'h3;
      cmd_opcode = OP_READ_DISPLAY_STATUS_WORD;
      cmd_valid = 1;
      @(negedge mclk);
      cmd_valid = 0;
      @(negedge mclk);
      run(OP_READ_GREEN_COMPONENT, 1);
      check(q[0], {2'h0, st.green});
      errs(130);
      rd_count();
      rd_count();
      errs(3);
      soft_reset = 1;
      @(negedge mclk);
      soft_reset = 0;
      pe = 0;
      pe_flag = 0;
      rd_count();
      q.delete();
      cmd_opcode = 8'h0a;
      cmd_valid = 1;
      @(negedge mclk);
      cmd_valid = 0;
      check(cmd_unknown, 1'b1);
      repeat (6) @(negedge mclk);
      check(q.size(), 0);
      wrap_up();
   end
endmodule
